//--- hw/clk_source_manager.sv
// main clock source manager: source switch, slow oscillator dividers, low-power gating
`timescale 1ns/1ns
module clk_source_manager #(
  parameter int TRIM_W = 8,
  parameter logic [TRIM_W-1:0] TRIM_DEFAULT = '0
) (
  input wire logic mclk, // 10 MHz system clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] addr, // register byte address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire clk_src_pkg::pmode_t power_mode, // system power mode
  input wire logic fast_osc_in, // fast oscillator clock pin
  input wire logic slow_osc_in, // slow oscillator clock pin
  input wire logic ext_clk_in, // external reference clock pin
  input wire logic usb_recovery_enable, // full-speed usb clock recovery on
  input wire logic usb_trim_up, // usb monitor: raise trim, pulse
  input wire logic usb_trim_down, // usb monitor: lower trim, pulse
  output logic main_clk_tick, // main clock enable pulse
  output logic internal_ref_peripheral_clock, // second divider pulse
  output logic fast_osc_enable, // fast oscillator power
  output logic slow_osc_enable, // slow oscillator power
  output logic slow_osc_range, // 0 = 2M, 1 = 8M
  output logic ext_osc_request, // external reference requested
  output logic external_ref_kind_select, // 0 clock, 1 crystal
  output logic [TRIM_W-1:0] fast_osc_fine_trim // fast oscillator fine trim
);
  // ********************
  // types and checks
  // ********************
  typedef enum logic [1:0] {
    SW_STEADY = 2'b00,
    SW_WAIT = 2'b01,
    SW_SWAP = 2'b11
  } sw_t;

  typedef struct packed {
    logic [1:0] main_source_select;
    logic slow_osc_clock_enable;
    logic slow_osc_stop_keep;
    logic ext_kind;
    logic range;
    logic [2:0] first_slow_osc_divider;
    logic fast_osc_force_enable;
    logic [2:0] second_slow_osc_divider;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [clk_src_pkg::DIV_CNT_W-1:0] cnt1;
    logic [clk_src_pkg::DIV_CNT_W-1:0] cnt2;
    logic div1_tick;
    sw_t sw;
    logic [1:0] target;
    logic [1:0] active;
    logic [1:0] main_source_status;
    logic keep_in_stop;
    logic in_stop;
    logic [TRIM_W-1:0] trim;
    logic main_tick;
    logic ref_tick;
    logic fast_en;
    logic slow_en;
    logic ext_req;
    logic [7:0] rdata;
  } state_t;

  if (TRIM_W < 2 || TRIM_W > 16) begin : g_chk
    $error("TRIM_W must be 2 to 16");
  end

  // ********************
  // helpers
  // ********************
  function automatic logic [clk_src_pkg::DIV_CNT_W-1:0] div_limit(input logic [2:0] code);
    logic [7:0] full;
    full = (8'h01 << code) - 8'h01;
    return full[clk_src_pkg::DIV_CNT_W-1:0];
  endfunction

  function automatic logic pick(input logic [1:0] code, input logic f, input logic s, input logic e);
    logic t;
    t = 1'b0;
    if (code == clk_src_pkg::SRC_FAST) begin
      t = f;
    end else if (code == clk_src_pkg::SRC_SLOW) begin
      t = s;
    end else if (code == clk_src_pkg::SRC_EXT) begin
      t = e;
    end
    return t;
  endfunction

  state_t r;
  state_t next_r;
  logic [2:0] edges;
  logic run_mode;
  logic vlp_mode;
  logic stop_mode;
  logic leak_mode;

  assign edges = r.s2 & ~r.s3;
  assign run_mode = power_mode == clk_src_pkg::PM_RUN;
  assign vlp_mode = power_mode == clk_src_pkg::PM_VERY_LOW_POWER_RUN || power_mode == clk_src_pkg::PM_VERY_LOW_POWER_WAIT;
  assign stop_mode = power_mode == clk_src_pkg::PM_STOP || power_mode == clk_src_pkg::PM_VERY_LOW_POWER_STOP;
  assign leak_mode = power_mode == clk_src_pkg::PM_LLS || power_mode == clk_src_pkg::PM_VERY_LOW_LEAKAGE_STOP;

  // ********************
  // next state
  // ********************
  always_comb begin
    next_r = r;
    next_r.s1 = {ext_clk_in, slow_osc_in, fast_osc_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.rdata = 8'h00;
    next_r.div1_tick = 1'b0;
    next_r.ref_tick = 1'b0;
    next_r.main_tick = 1'b0;

    // register writes
    if (wr) begin
      unique case (addr)
        clk_src_pkg::OFS_CTRL1: begin
          next_r.main_source_select = wdata[clk_src_pkg::SEL_HI:clk_src_pkg::SEL_LO];
          next_r.slow_osc_clock_enable = wdata[clk_src_pkg::BIT_CLKEN];
          next_r.slow_osc_stop_keep = wdata[clk_src_pkg::BIT_STOPKEEP];
        end
        clk_src_pkg::OFS_CTRL2: begin
          next_r.ext_kind = wdata[clk_src_pkg::BIT_EXTKIND];
          // shared 2M/8M circuit: range frozen while the slow source is in use
          if (r.active != clk_src_pkg::SRC_SLOW && r.main_source_status != clk_src_pkg::SRC_SLOW) begin
            next_r.range = wdata[clk_src_pkg::BIT_RANGE];
          end
        end
        clk_src_pkg::OFS_DIVCTRL: begin
          next_r.first_slow_osc_divider = wdata[clk_src_pkg::DIV1_HI:clk_src_pkg::DIV1_LO];
        end
        clk_src_pkg::OFS_MISC: begin
          next_r.fast_osc_force_enable = wdata[clk_src_pkg::BIT_FORCE];
          next_r.second_slow_osc_divider = wdata[clk_src_pkg::DIV2_HI:clk_src_pkg::DIV2_LO];
        end
        default: begin
        end
      endcase
    end

    // register reads; unmapped addresses read zero
    if (rd) begin
      unique case (addr)
        clk_src_pkg::OFS_CTRL1: begin
          next_r.rdata[clk_src_pkg::SEL_HI:clk_src_pkg::SEL_LO] = r.main_source_select;
          next_r.rdata[clk_src_pkg::BIT_CLKEN] = r.slow_osc_clock_enable;
          next_r.rdata[clk_src_pkg::BIT_STOPKEEP] = r.slow_osc_stop_keep;
        end
        clk_src_pkg::OFS_CTRL2: begin
          next_r.rdata[clk_src_pkg::BIT_EXTKIND] = r.ext_kind;
          next_r.rdata[clk_src_pkg::BIT_RANGE] = r.range;
        end
        clk_src_pkg::OFS_STATUS: begin
          next_r.rdata[clk_src_pkg::STAT_HI:clk_src_pkg::STAT_LO] = r.main_source_status;
        end
        clk_src_pkg::OFS_DIVCTRL: begin
          next_r.rdata[clk_src_pkg::DIV1_HI:clk_src_pkg::DIV1_LO] = r.first_slow_osc_divider;
        end
        clk_src_pkg::OFS_MISC: begin
          // bits 6..3 stay zero from the default above
          next_r.rdata[clk_src_pkg::BIT_FORCE] = r.fast_osc_force_enable;
          next_r.rdata[clk_src_pkg::DIV2_HI:clk_src_pkg::DIV2_LO] = r.second_slow_osc_divider;
        end
        default: begin
        end
      endcase
    end

    // slow dividers
    if (edges[1]) begin
      if (r.cnt1 >= div_limit(r.first_slow_osc_divider)) begin
        next_r.cnt1 = '0;
        next_r.div1_tick = 1'b1;
      end else begin
        next_r.cnt1 = r.cnt1 + 1'b1;
      end
    end
    if (r.div1_tick) begin
      // first divider output clocks the second one
      if (r.cnt2 >= div_limit(r.second_slow_osc_divider)) begin
        next_r.cnt2 = '0;
        next_r.ref_tick = 1'b1;
      end else begin
        next_r.cnt2 = r.cnt2 + 1'b1;
      end
    end

    // main switch: wait for a whole pulse of the new source, then swap
    unique case (r.sw)
      SW_STEADY: begin
        if (r.main_source_select != r.active) begin
          next_r.target = r.main_source_select;
          next_r.sw = SW_WAIT;
        end
      end
      SW_WAIT: begin
        next_r.target = r.main_source_select;
        if (r.main_source_select == r.active) begin
          next_r.sw = SW_STEADY;
        end else if (pick(r.main_source_select, edges[0], r.div1_tick, edges[2])) begin
          next_r.active = r.main_source_select;
          next_r.sw = SW_SWAP;
        end
      end
      SW_SWAP: begin
        next_r.main_source_status = r.active;
        next_r.sw = SW_STEADY;
      end
      default: begin
        next_r.sw = SW_STEADY;
      end
    endcase
    // whole pulses only: old source stops the cycle the new one starts
    next_r.main_tick = pick(next_r.active, edges[0], r.div1_tick, edges[2]) & ~stop_mode;

    // oscillator enables
    next_r.in_stop = stop_mode;
    if (stop_mode && !r.in_stop) begin
      next_r.keep_in_stop = r.slow_osc_stop_keep & r.slow_osc_clock_enable;
    end
    next_r.fast_en = run_mode & (r.fast_osc_force_enable | r.active == clk_src_pkg::SRC_FAST
      | (r.sw != SW_STEADY && r.target == clk_src_pkg::SRC_FAST));
    next_r.slow_en = (run_mode | vlp_mode) & (r.slow_osc_clock_enable | r.active == clk_src_pkg::SRC_SLOW
      | (r.sw != SW_STEADY && r.target == clk_src_pkg::SRC_SLOW));
    if (stop_mode) begin
      next_r.slow_en = next_r.keep_in_stop;
    end
    next_r.ext_req = (run_mode | vlp_mode) & (r.active == clk_src_pkg::SRC_EXT
      | (r.sw != SW_STEADY && r.target == clk_src_pkg::SRC_EXT));
    // usb recovery trims the fast oscillator from its default
    if (!usb_recovery_enable) begin
      next_r.trim = TRIM_DEFAULT;
    end else if (usb_trim_up && !usb_trim_down && r.trim != '1) begin
      next_r.trim = r.trim + 1'b1;
    end else if (usb_trim_down && !usb_trim_up && r.trim != '0) begin
      next_r.trim = r.trim - 1'b1;
    end
    // leakage modes: all clocks and counters off, settings retained
    if (leak_mode) begin
      next_r.fast_en = 1'b0;
      next_r.slow_en = 1'b0;
      next_r.ext_req = 1'b0;
      next_r.main_tick = 1'b0;
      next_r.ref_tick = 1'b0;
      next_r.div1_tick = 1'b0;
      next_r.cnt1 = '0;
      next_r.cnt2 = '0;
    end
  end

  // ********************
  // state register
  // ********************
  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= '0;
      r.main_source_select <= clk_src_pkg::RST_SEL;
      r.active <= clk_src_pkg::RST_SEL;
      r.target <= clk_src_pkg::RST_SEL;
      r.main_source_status <= clk_src_pkg::RST_SEL;
      r.first_slow_osc_divider <= clk_src_pkg::RST_DIV;
      r.second_slow_osc_divider <= clk_src_pkg::RST_DIV;
      r.sw <= SW_STEADY;
      r.trim <= TRIM_DEFAULT;
      r.slow_en <= 1'b1;
      // synchronisers run through reset: a pin held high gives no false edge
      r.s1 <= next_r.s1;
      r.s2 <= next_r.s2;
      r.s3 <= next_r.s3;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
  assign main_clk_tick = r.main_tick;
  assign internal_ref_peripheral_clock = r.ref_tick;
  assign fast_osc_enable = r.fast_en;
  assign slow_osc_enable = r.slow_en;
  assign slow_osc_range = r.range;
  assign ext_osc_request = r.ext_req;
  assign external_ref_kind_select = r.ext_kind;
  assign fast_osc_fine_trim = r.trim;

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_force_fast;
    r.fast_osc_force_enable && run_mode |=> fast_osc_enable;
  endproperty
  a_force_fast: assert property (p_force_fast) else $error("forced fast oscillator off");
  property p_ref_from_div1;
    internal_ref_peripheral_clock |-> $past(r.div1_tick) && $past(r.cnt2) >= div_limit($past(r.second_slow_osc_divider));
  endproperty
  a_ref_from_div1: assert property (p_ref_from_div1) else $error("reference pulse without divider");
  property p_range_lock;
    wr && addr == clk_src_pkg::OFS_CTRL2 && r.active == clk_src_pkg::SRC_SLOW |=> $stable(slow_osc_range);
  endproperty
  a_range_lock: assert property (p_range_lock) else $error("range changed in slow mode");
  property p_select_starts;
    r.sw == SW_STEADY && r.main_source_select != r.active |=> r.sw == SW_WAIT ##1 r.sw != SW_STEADY;
  endproperty
  a_select_starts: assert property (p_select_starts) else $error("select not acted on");
  property p_stop_gating;
    stop_mode ##1 stop_mode |-> !fast_osc_enable && !main_clk_tick && slow_osc_enable == r.keep_in_stop;
  endproperty
  a_stop_gating: assert property (p_stop_gating) else $error("stop gating wrong");
  property p_leak_off;
    leak_mode |=> !fast_osc_enable && !slow_osc_enable && !main_clk_tick && !internal_ref_peripheral_clock;
  endproperty
  a_leak_off: assert property (p_leak_off) else $error("clock active in leakage mode");
  property p_vlp_fast_off;
    vlp_mode |=> !fast_osc_enable;
  endproperty
  a_vlp_fast_off: assert property (p_vlp_fast_off) else $error("fast oscillator on in vlp");
  property p_trim_default;
    !usb_recovery_enable |=> fast_osc_fine_trim == TRIM_DEFAULT;
  endproperty
  a_trim_default: assert property (p_trim_default) else $error("trim not at default");
  property p_misc_zero;
    rd && addr == clk_src_pkg::OFS_MISC |=> rdata[6:3] == 4'h0;
  endproperty
  a_misc_zero: assert property (p_misc_zero) else $error("misc reserved bits nonzero");
  // a swap already under way may legally land in the cycle of the write
  property p_status_late;
    wr && addr == clk_src_pkg::OFS_CTRL1 && r.sw != SW_SWAP |=> $stable(r.main_source_status);
  endproperty
  a_status_late: assert property (p_status_late) else $error("status followed write at once");
  property p_status_after_swap;
    $changed(r.main_source_status) |-> $past(r.sw) == SW_SWAP && r.main_source_status == r.active;
  endproperty
  a_status_after_swap: assert property (p_status_after_swap) else $error("status before swap");

endmodule // clk_source_manager

//--- hw/clk_src_pkg.sv
// shared constants and types for the clock source manager
package clk_src_pkg;
  // ********************
  // register map
  // ********************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h01;
  localparam logic [7:0] OFS_STATUS = 8'h06;
  localparam logic [7:0] OFS_DIVCTRL = 8'h08;
  localparam logic [7:0] OFS_MISC = 8'h18;
  // ctrl1 fields
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int BIT_CLKEN = 1;
  localparam int BIT_STOPKEEP = 0;
  // ctrl2 fields
  localparam int BIT_EXTKIND = 2;
  localparam int BIT_RANGE = 0;
  // status fields
  localparam int STAT_HI = 3;
  localparam int STAT_LO = 2;
  // divctrl fields
  localparam int DIV1_HI = 3;
  localparam int DIV1_LO = 1;
  // misc fields
  localparam int BIT_FORCE = 7;
  localparam int DIV2_HI = 2;
  localparam int DIV2_LO = 0;
  // ********************
  // source codes and reset values
  // ********************
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] RST_SEL = SRC_SLOW;
  localparam logic [2:0] RST_DIV = 3'h0;
  localparam int DIV_CNT_W = 7;
  // ********************
  // power modes
  // ********************
  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_VERY_LOW_POWER_RUN = 3'h1,
    PM_VERY_LOW_POWER_WAIT = 3'h2,
    PM_STOP = 3'h3,
    PM_VERY_LOW_POWER_STOP = 3'h4,
    PM_LLS = 3'h5,
    PM_VERY_LOW_LEAKAGE_STOP = 3'h6
  } pmode_t;
endpackage

//--- testbench/tb_clk_source_manager.sv
// self-checking testbench for the clock source manager
`timescale 1ns/1ns
module tb_clk_source_manager;
  localparam logic [7:0] TRIM_INIT = 8'h40;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  clk_src_pkg::pmode_t power_mode = clk_src_pkg::PM_RUN;
  logic fast_osc_in = 1'b0;
  logic slow_osc_in = 1'b0;
  logic ext_clk_in = 1'b0;
  logic usb_recovery_enable = 1'b0;
  logic usb_trim_up = 1'b0;
  logic usb_trim_down = 1'b0;
  logic main_clk_tick, internal_ref_peripheral_clock, fast_osc_enable, slow_osc_enable;
  logic slow_osc_range, ext_osc_request, external_ref_kind_select;
  logic [7:0] fast_osc_fine_trim;
  int fail_count = 0;
  int compares = 0;
  int tick_cnt = 0;
  int ref_cnt = 0;
  int slow_edges = 0;
  logic slow_run = 1'b1;
  logic [1:0] ph = 2'h0;
  logic [7:0] v;

  clk_source_manager #(.TRIM_W(8), .TRIM_DEFAULT(TRIM_INIT)) u_clk_source_manager (
    .mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .power_mode(power_mode), .fast_osc_in(fast_osc_in), .slow_osc_in(slow_osc_in), .ext_clk_in(ext_clk_in),
    .usb_recovery_enable(usb_recovery_enable), .usb_trim_up(usb_trim_up), .usb_trim_down(usb_trim_down),
    .main_clk_tick(main_clk_tick), .internal_ref_peripheral_clock(internal_ref_peripheral_clock),
    .fast_osc_enable(fast_osc_enable), .slow_osc_enable(slow_osc_enable), .slow_osc_range(slow_osc_range),
    .ext_osc_request(ext_osc_request), .external_ref_kind_select(external_ref_kind_select),
    .fast_osc_fine_trim(fast_osc_fine_trim));

  always #50 mclk = ~mclk;

  // ********************
  // oscillator pins and pulse counters
  // ********************
  always @(posedge mclk) begin
    fast_osc_in <= ~fast_osc_in;
    ph <= ph + 2'h1;
    if (ph[0]) begin
      ext_clk_in <= ~ext_clk_in;
    end
    // slow pin is gated so divider windows hold an exact number of edges
    if (slow_run && ph == 2'h3) begin
      slow_osc_in <= ~slow_osc_in;
      if (!slow_osc_in) begin
        slow_edges <= slow_edges + 1;
      end
    end
    if (main_clk_tick === 1'b1) begin
      tick_cnt <= tick_cnt + 1;
    end
    if (internal_ref_peripheral_clock === 1'b1) begin
      ref_cnt <= ref_cnt + 1;
    end
  end

  // ********************
  // bus tasks and compares
  // ********************
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // status polling is bounded; the swap waits for a synced edge of the new source
  task automatic wait_status(input logic [1:0] src);
    int i;
    for (i = 0; i < 100; i++) begin
      reg_read(clk_src_pkg::OFS_STATUS, v);
      if (v[3:2] === src) break;
    end
    check("status", {6'h00, src}, {6'h00, v[3:2]});
  endtask

  task automatic trim_pulse(input logic up, input logic down);
    @(posedge mclk);
    usb_trim_up <= up;
    usb_trim_down <= down;
    @(posedge mclk);
    usb_trim_up <= 1'b0;
    usb_trim_down <= 1'b0;
  endtask

  task automatic set_mode(input clk_src_pkg::pmode_t m);
    @(posedge mclk);
    power_mode <= m;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
  endtask

  task automatic div_run(input logic [2:0] c1, input logic [2:0] c2);
    slow_run = 1'b0;
    do_reset();
    reg_write(clk_src_pkg::OFS_DIVCTRL, {4'h0, c1, 1'b0});
    reg_write(clk_src_pkg::OFS_MISC, {5'h00, c2});
    settle(4);
    tick_cnt = 0;
    ref_cnt = 0;
    slow_edges = 0;
    slow_run = 1'b1;
    while (slow_edges < 128) @(posedge mclk);
    slow_run = 1'b0;
    settle(12);
    check("main_ticks", 8'(128 >> c1), 8'(tick_cnt));
    check("ref_pulses", 8'(128 >> (c1 + c2)), 8'(ref_cnt));
  endtask

  task automatic report_and_stop();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ********************
  // watchdog
  // ********************
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end

  // ********************
  // test sequence
  // ********************
  initial begin
    do_reset();
    settle(1);
    check("slow_en", 8'h01, {7'h00, slow_osc_enable});
    check("fast_en", 8'h00, {7'h00, fast_osc_enable});
    check("trim", TRIM_INIT, fast_osc_fine_trim);
    reg_read(clk_src_pkg::OFS_STATUS, v);
    check("status", 8'h01, {6'h00, v[3:2]});
    reg_write(8'h05, 8'hff);
    reg_read(8'h05, v);
    check("unmapped", 8'h00, v);
    reg_write(clk_src_pkg::OFS_MISC, 8'hff);
    reg_read(clk_src_pkg::OFS_MISC, v);
    check("misc", 8'h87, v);
    settle(2);
    check("fast_en", 8'h01, {7'h00, fast_osc_enable});
    reg_write(clk_src_pkg::OFS_MISC, 8'h00);
    settle(2);
    check("fast_en", 8'h00, {7'h00, fast_osc_enable});
    // stop keeps slow only with both keep and enable set before entry
    reg_write(clk_src_pkg::OFS_CTRL1, 8'h43);
    set_mode(clk_src_pkg::PM_STOP);
    settle(3);
    check("slow_en", 8'h01, {7'h00, slow_osc_enable});
    set_mode(clk_src_pkg::PM_RUN);
    reg_write(clk_src_pkg::OFS_CTRL1, 8'h42);
    set_mode(clk_src_pkg::PM_VERY_LOW_POWER_STOP);
    settle(3);
    check("slow_en", 8'h00, {7'h00, slow_osc_enable});
    check("fast_en", 8'h00, {7'h00, fast_osc_enable});
    // force bit left set: low-power wait must still hold the fast oscillator off
    set_mode(clk_src_pkg::PM_RUN);
    reg_write(clk_src_pkg::OFS_MISC, 8'h80);
    set_mode(clk_src_pkg::PM_VERY_LOW_POWER_WAIT);
    settle(3);
    check("fast_en", 8'h00, {7'h00, fast_osc_enable});
    check("slow_en", 8'h01, {7'h00, slow_osc_enable});
    // low-power run entered from slow mode with the force bit cleared
    set_mode(clk_src_pkg::PM_RUN);
    reg_write(clk_src_pkg::OFS_MISC, 8'h00);
    set_mode(clk_src_pkg::PM_VERY_LOW_POWER_RUN);
    reg_write(clk_src_pkg::OFS_CTRL1, 8'h42);
    settle(3);
    check("fast_en", 8'h00, {7'h00, fast_osc_enable});
    check("slow_en", 8'h01, {7'h00, slow_osc_enable});
    set_mode(clk_src_pkg::PM_LLS);
    settle(3);
    check("slow_en", 8'h00, {7'h00, slow_osc_enable});
    set_mode(clk_src_pkg::PM_VERY_LOW_LEAKAGE_STOP);
    settle(3);
    check("ticks", 8'h00, {6'h00, main_clk_tick, internal_ref_peripheral_clock});
    set_mode(clk_src_pkg::PM_RUN);
    reg_write(clk_src_pkg::OFS_MISC, 8'h00);
    reg_write(clk_src_pkg::OFS_CTRL2, 8'h01);
    settle(1);
    check("range", 8'h00, {7'h00, slow_osc_range});
    reg_write(clk_src_pkg::OFS_CTRL1, {clk_src_pkg::SRC_FAST, 6'h02});
    reg_read(clk_src_pkg::OFS_STATUS, v);
    check("status", 8'h01, {6'h00, v[3:2]});
    wait_status(clk_src_pkg::SRC_FAST);
    check("fast_en", 8'h01, {7'h00, fast_osc_enable});
    reg_write(clk_src_pkg::OFS_CTRL2, 8'h01);
    settle(1);
    check("range", 8'h01, {7'h00, slow_osc_range});
    reg_write(clk_src_pkg::OFS_CTRL1, {clk_src_pkg::SRC_SLOW, 6'h02});
    wait_status(clk_src_pkg::SRC_SLOW);
    reg_write(clk_src_pkg::OFS_CTRL2, 8'h04);
    settle(1);
    check("range", 8'h01, {7'h00, slow_osc_range});
    check("kind", 8'h01, {7'h00, external_ref_kind_select});
    reg_write(clk_src_pkg::OFS_CTRL1, {clk_src_pkg::SRC_EXT, 6'h02});
    wait_status(clk_src_pkg::SRC_EXT);
    check("ext_req", 8'h01, {7'h00, ext_osc_request});
    // trim follows the monitor only while recovery is on
    @(posedge mclk);
    usb_recovery_enable <= 1'b1;
    trim_pulse(1'b1, 1'b0);
    trim_pulse(1'b1, 1'b0);
    trim_pulse(1'b1, 1'b1);
    trim_pulse(1'b0, 1'b1);
    settle(1);
    check("trim", TRIM_INIT + 8'h01, fast_osc_fine_trim);
    @(posedge mclk);
    usb_recovery_enable <= 1'b0;
    settle(2);
    check("trim", TRIM_INIT, fast_osc_fine_trim);
    div_run(3'h0, 3'h0);
    div_run(3'h3, 3'h2);
    div_run(3'h7, 3'h0);
    div_run(3'h1, 3'h6);
    report_and_stop();
  end
endmodule // tb_clk_source_manager
